// file: sram_sleep_params.svh
// Offsets, field positions, reset values and sizes of the burst SRAM control block
`ifndef SRAM_SLEEP_PARAMS_SVH
`define SRAM_SLEEP_PARAMS_SVH

`define SRAM_ADDR_W          10
`define SRAM_DATA_W          36
`define SRAM_BURST_W         2

`define REG_CTRL_OFS         8'h00
`define REG_STATUS_OFS       8'h04
`define REG_STALL_CNT_OFS    8'h08

`define CTRL_FORCE_SLEEP_BIT 0
`define CTRL_RESET           1'b0

`define STAT_SLEEP_BIT       0
`define STAT_SELECTED_BIT    1
`define STAT_ORDER_BIT       2
`define STAT_STALLED_BIT     3
`define STAT_OUT_VALID_BIT   4

`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_DECERR      2'h3

`endif

// file: sram_sleep_pkg.sv
// Types shared by the burst SRAM control block
`include "sram_sleep_params.svh"

package sram_sleep_pkg;

    typedef enum logic {
        MODE_ACTIVE,
        MODE_SLEEP
    } power_mode_t;

    typedef struct packed {
        logic                      first_low;
        logic                      second_high;
        logic                      third_low;
    } chip_select_t;

    typedef struct packed {
        power_mode_t               mode;
        logic                      op_valid;
        logic                      op_write;
        logic [`SRAM_ADDR_W-1:0]   op_addr;
        logic [`SRAM_ADDR_W-1:0]   burst_base;
        logic [`SRAM_BURST_W-1:0]  burst_cnt;
        logic                      burst_ok;
        logic                      out_valid;
        logic                      selected;
        logic                      stalled;
        logic                      force_sleep;
        logic [31:0]               stall_count;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [1:0]                rresp;
        logic [31:0]               rdata;
    } ctrl_state_t;

endpackage

// file: sram_store.sv
// Storage array with registered read data
`timescale 1ns/1ps
`default_nettype none

module sram_store #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 36
) (
    input  wire logic              clk_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // No reset: contents survive reset and sleep alike
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (rd_en_i) begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule

`default_nettype wire

// file: sram_sleep_ctrl.sv
// Burst SRAM control: select decode, burst order, stall, sleep, AXI4-Lite status
//
// Operation
// - The device counts as selected only with first select low, second high, third low.
// - The order strap picks linear bursts at 0 and interleaved bursts at 1.
// - An edge with the clock qualifier deasserted is a stall and performs no write.
// - On leaving sleep the data pins stay high impedance.
// - A high sleep request puts the device in sleep and keeps the array intact.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sram_sleep_params.svh"

module sram_sleep_ctrl
    import sram_sleep_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    chip_select_first_low_i,
    input  wire logic                    chip_select_second_high_i,
    input  wire logic                    chip_select_third_low_i,
    input  wire logic                    clock_qualifier_n_i,
    input  wire logic                    sleep_request_i,
    input  wire logic                    burst_order_i,
    input  wire logic                    adv_load_i,
    input  wire logic                    write_enable_n_i,
    input  wire logic [`SRAM_ADDR_W-1:0] addr_i,
    input  wire logic [`SRAM_DATA_W-1:0] dq_i,
    output logic      [`SRAM_DATA_W-1:0] dq_o,
    output logic                         dq_oe_n_o,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic      [1:0]              s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic      [31:0]             s_axi_rdata,
    output logic      [1:0]              s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);

    ctrl_state_t                 state_reg;
    ctrl_state_t                 state_next;
    chip_select_t                cs;
    logic                        sleeping;
    logic                        advance;
    logic                        selected;
    logic                        mem_wr;
    logic                        mem_rd;
    logic                        wr_take;
    logic                        rd_take;
    logic [31:0]                 status_word;

    // Low bits follow the burst order; upper bits stay with the base
    function automatic logic [`SRAM_ADDR_W-1:0] burst_addr(
        input logic [`SRAM_ADDR_W-1:0]  base,
        input logic [`SRAM_BURST_W-1:0] cnt,
        input logic                     interleaved
    );
        logic [`SRAM_BURST_W-1:0] low;
        low = interleaved ? (base[`SRAM_BURST_W-1:0] ^ cnt)
                          : (base[`SRAM_BURST_W-1:0] + cnt);
        return {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
    endfunction

    assign cs = '{first_low:   chip_select_first_low_i,
                  second_high: chip_select_second_high_i,
                  third_low:   chip_select_third_low_i};

    assign selected = !cs.first_low && cs.second_high && !cs.third_low;

    // sleep by pin or by software
    assign sleeping = sleep_request_i || state_reg.force_sleep;

    assign advance = !clock_qualifier_n_i && !sleeping;

    // writes only on a live edge
    assign mem_wr = advance && state_reg.op_valid && state_reg.op_write;
    assign mem_rd = advance && state_reg.op_valid && !state_reg.op_write;

    assign wr_take = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
    assign rd_take = s_axi_arvalid && !state_reg.rvalid;

    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = rd_take;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rresp   = state_reg.rresp;
    assign s_axi_rdata   = state_reg.rdata;

    // pins driven only while a read result is held
    assign dq_oe_n_o = !state_reg.out_valid;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_SLEEP_BIT]     = (state_reg.mode == MODE_SLEEP);
        status_word[`STAT_SELECTED_BIT]  = state_reg.selected;
        status_word[`STAT_ORDER_BIT]     = burst_order_i;
        status_word[`STAT_STALLED_BIT]   = state_reg.stalled;
        status_word[`STAT_OUT_VALID_BIT] = state_reg.out_valid;
    end

    always_comb begin
        state_next = state_reg;
        state_next.stalled = clock_qualifier_n_i;

        case (state_reg.mode)
            MODE_ACTIVE: begin
                if (sleeping) begin
                    state_next.mode = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (!sleeping) begin
                    state_next.mode = MODE_ACTIVE;
                end
            end
            default: begin
                state_next.mode = MODE_ACTIVE;
            end
        endcase

        if (sleeping) begin
            state_next.op_valid  = 1'b0;
            state_next.burst_ok  = 1'b0;
            state_next.selected  = 1'b0;
            // no stale read data after wake-up
            state_next.out_valid = 1'b0;
        end else if (advance) begin
            state_next.out_valid = state_reg.op_valid && !state_reg.op_write;
            if (adv_load_i) begin
                if (state_reg.burst_ok) begin
                    state_next.op_valid  = 1'b1;
                    state_next.burst_cnt = state_reg.burst_cnt + 1'b1;
                    state_next.op_addr   = burst_addr(state_reg.burst_base,
                                                      state_reg.burst_cnt + 1'b1,
                                                      burst_order_i);
                end else begin
                    state_next.op_valid = 1'b0;
                end
            end else if (selected) begin
                state_next.op_valid   = 1'b1;
                state_next.op_write   = !write_enable_n_i;
                state_next.op_addr    = addr_i;
                state_next.burst_base = addr_i;
                state_next.burst_cnt  = '0;
                state_next.burst_ok   = 1'b1;
                state_next.selected   = 1'b1;
            end else begin
                state_next.op_valid = 1'b0;
                state_next.burst_ok = 1'b0;
                state_next.selected = 1'b0;
            end
        end else begin
            state_next.stall_count = state_reg.stall_count + 32'h0000_0001;
        end

        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (wr_take) begin
            state_next.bvalid = 1'b1;
            if (s_axi_awaddr == `REG_CTRL_OFS) begin
                if (s_axi_wstrb[0]) begin
                    state_next.force_sleep = s_axi_wdata[`CTRL_FORCE_SLEEP_BIT];
                end
                state_next.bresp = `AXI_RESP_OKAY;
            end else if (s_axi_awaddr == `REG_STATUS_OFS ||
                         s_axi_awaddr == `REG_STALL_CNT_OFS) begin
                state_next.bresp = `AXI_RESP_OKAY;
            end else begin
                state_next.bresp = `AXI_RESP_DECERR;
            end
        end

        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_take) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = `AXI_RESP_OKAY;
            if (s_axi_araddr == `REG_CTRL_OFS) begin
                state_next.rdata = 32'h0000_0000;
                state_next.rdata[`CTRL_FORCE_SLEEP_BIT] = state_reg.force_sleep;
            end else if (s_axi_araddr == `REG_STATUS_OFS) begin
                state_next.rdata = status_word;
            end else if (s_axi_araddr == `REG_STALL_CNT_OFS) begin
                state_next.rdata = state_reg.stall_count;
            end else begin
                state_next.rdata = 32'h0000_0000;
                state_next.rresp = `AXI_RESP_DECERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg             <= '0;
            state_reg.mode        <= MODE_ACTIVE;
            state_reg.force_sleep <= `CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read data register sits in the array, so a stall also freezes dq_o
    sram_store #(
        .ADDR_W (`SRAM_ADDR_W),
        .DATA_W (`SRAM_DATA_W)
    ) u_store (
        .clk_i   (clk_i),
        .wr_en_i (mem_wr),
        .rd_en_i (mem_rd),
        .addr_i  (state_reg.op_addr),
        .wdata_i (dq_i),
        .rdata_o (dq_o)
    );

endmodule

`default_nettype wire

// file: sram_sleep_properties.sv
// Port assertions for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
`include "sram_sleep_params.svh"
module sram_sleep_properties (
    input wire logic                    clk_i,
    input wire logic                    reset_i,
    input wire logic                    chip_select_first_low_i,
    input wire logic                    chip_select_second_high_i,
    input wire logic                    chip_select_third_low_i,
    input wire logic                    clock_qualifier_n_i,
    input wire logic                    sleep_request_i,
    input wire logic                    adv_load_i,
    input wire logic                    write_enable_n_i,
    input wire logic [`SRAM_DATA_W-1:0] dq_o,
    input wire logic                    dq_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic live;
    logic sel;
    assign live = !clock_qualifier_n_i && !sleep_request_i;
    assign sel  = !chip_select_first_low_i && chip_select_second_high_i
                  && !chip_select_third_low_i;
    sequence rd_load;
        live && sel && !adv_load_i && write_enable_n_i;
    endsequence
    sequence stall_edge;
        clock_qualifier_n_i && !sleep_request_i;
    endsequence
    a_read_drives:
        assert property (rd_load ##1 live |=> !dq_oe_n_o) else $error("read not driven");
    a_desel_quiet:
        assert property (live && !sel && !adv_load_i ##1 live |=> dq_oe_n_o)
        else $error("deselected cycle drove pins");
    a_stall_freeze:
        assert property (stall_edge |=> $stable(dq_o) && $stable(dq_oe_n_o))
        else $error("outputs moved on a stall edge");
    a_stall_read_wait:
        assert property (rd_load ##1 stall_edge [*2] ##1 live |=> !dq_oe_n_o)
        else $error("read lost across stall");
    a_sleep_hiz:
        assert property (sleep_request_i |=> dq_oe_n_o) else $error("pins driven in sleep");
    a_wake_hiz:
        assert property ($fell(sleep_request_i) |-> dq_oe_n_o [*2])
        else $error("pins driven on wake");
endmodule
bind sram_sleep_ctrl sram_sleep_properties u_props (
    .clk_i, .reset_i, .chip_select_first_low_i, .chip_select_second_high_i,
    .chip_select_third_low_i, .clock_qualifier_n_i, .sleep_request_i, .adv_load_i,
    .write_enable_n_i, .dq_o, .dq_oe_n_o
);
`default_nettype wire

// file: mem_ctrl_model.sv
// Memory controller model driving selects, qualifier, sleep and write data
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model
    import sram_sleep_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         stall_i,
    input  wire logic         sleep_i,
    input  wire logic         dval_i,
    input  wire chip_select_t sel_i,
    input  wire logic [35:0]  data_i,
    output chip_select_t      cs_o,
    output logic              qual_n_o,
    output logic              sleep_o,
    output logic      [35:0]  dq_o
);
    logic        sleep_q = 1'b0;
    logic        desel_q = 1'b0;
    logic [35:0] last_q  = 36'h0;
    assign cs_o     = (sleep_i || sleep_q) ? 3'b110 : sel_i;
    assign sleep_o  = sleep_q;
    assign qual_n_o = stall_i;
    // Idle bus toggles so stale data never looks valid
    assign dq_o     = dval_i ? data_i : ~last_q;
    always_ff @(posedge clk_i) begin
        desel_q <= (cs_o != 3'b010);
        // sleep only after a deselected edge
        sleep_q <= sleep_i && (sleep_q || desel_q);
        last_q  <= dq_o;
    end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sram_sleep_pkg::*;
    logic clk_i = 0, reset_i = 1, burst_order_i = 0, adv_load_i = 0, write_enable_n_i = 1;
    logic [9:0]  addr_i = 0, pa, ra, ba, cur, a;
    logic [35:0] dq_o, dqi, dat = 0, pd = 0, ev;
    logic dq_oe_n_o, stall = 0, slp = 0, dval = 0, cq, sq, pw = 0, rdp = 0, chk = 0;
    logic opw = 0, go = 0, ord = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, drv = 0, aw, wd, ar, fin;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, bc;
    chip_select_t sel = 3'b110, cs;
    logic [35:0] mem [0:1023];
    integer seed = 32'hCA9F7578;
    int fail_count = 0, compares = 0, nst = 0, i, k;
    always #25 clk_i = ~clk_i;
    mem_ctrl_model peer (.clk_i, .stall_i(stall), .sleep_i(slp), .dval_i(dval), .sel_i(sel),
        .data_i(dat), .cs_o(cs), .qual_n_o(cq), .sleep_o(sq), .dq_o(dqi));
    sram_sleep_ctrl DUT (.chip_select_first_low_i(cs.first_low), .clock_qualifier_n_i(cq),
        .chip_select_second_high_i(cs.second_high), .chip_select_third_low_i(cs.third_low),
        .sleep_request_i(sq), .dq_i(dqi), .*);
    task ck(input string n, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function logic [9:0] nx(input logic [9:0] b, input logic [1:0] c);
        nx = ord ? (b ^ {8'h0, c}) : {b[9:2], b[1:0] + c};
    endfunction
    // One memory-side edge; the bench mirrors the array to predict reads
    task mc(input logic st, ld, wr, input logic [2:0] s, input logic [9:0] ad,
            input logic [35:0] d);
        stall <= st; adv_load_i <= !ld; write_enable_n_i <= !wr; sel <= s; addr_i <= ad;
        dval <= pw;
        // Corrupt data on stalls: a write taken there shows up later
        dat <= st ? ~pd : pd;
        // Look mid-cycle, once the last live edge has settled
        @(negedge clk_i);
        ck("dq_oe_n_o", 36'(!drv), {35'h0, dq_oe_n_o});
        if (chk) begin
            chk = 0;
            ck("dq_o", ev, dq_o);
        end
        @(posedge clk_i);
        nst += st;
        if (!st) begin
            drv = rdp;
            if (rdp) begin chk = 1; ev = mem[ra]; end
            if (pw) mem[pa] = pd;
            pw = 0; rdp = 0;
            if (ld) begin go = (s == 3'b010); ba = ad; bc = 0; opw = wr; end
            else bc++;
            cur = nx(ba, bc);
            if (go && opw) begin pw = 1; pa = cur; pd = d; end
            if (go && !opw) begin rdp = 1; ra = cur; end
        end
    endtask
    task idle;
        mc(0, 1, 0, 3'b110, 0, 0);
        mc(0, 1, 0, 3'b110, 0, 0);
    endtask
    task ax(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        s_axi_awaddr <= ad; s_axi_araddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= wr;
        s_axi_wvalid <= wr; s_axi_bready <= wr; s_axi_arvalid <= !wr; s_axi_rready <= !wr;
        for (k = 0; k < 50; k++) begin
            // Snapshot before the edge: what the slave shows as that edge samples it
            @(negedge clk_i);
            aw = s_axi_awready;
            wd = s_axi_wready;
            ar = s_axi_arready;
            fin = wr ? s_axi_bvalid : s_axi_rvalid;
            r = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 0;
            if (wd) s_axi_wvalid <= 0;
            if (ar) s_axi_arvalid <= 0;
            if (fin) break;
        end
        s_axi_bready <= 0; s_axi_rready <= 0;
        if (k == 50) begin fail_count++; finish_test; end
        @(posedge clk_i);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 0;
        idle;
        ax(0, 8'h04, 0); ck("order", 36'h0, {35'h0, q[2]});
        ax(0, 8'h0C, 0); ck("resp", 36'h3, {34'h0, r});
        ax(1, 8'h00, 1); ax(0, 8'h00, 0); ck("ctrl", 36'h1, {4'h0, q});
        ax(1, 8'h00, 0);
        for (i = 0; i < 8; i++) mc(0, 1, 1, 3'b010, 10'h100 + i, $random(seed));
        for (i = 0; i < 8; i++) mc(0, 1, 1, i[2:0], 10'h100 + i, $random(seed));
        for (i = 0; i < 8; i++) mc(0, 1, 0, 3'b010, 10'h100 + i, 0);
        idle;
        for (i = 0; i < 2; i++) begin
            ord = i[0]; burst_order_i <= ord; q = $random(seed); a = 10'h200 + q[7:0];
            mc(0, 1, 1, 3'b010, a, $random(seed));
            for (k = 1; k < 4; k++) mc(0, 0, 1, 3'b010, a, $random(seed));
            for (k = 0; k < 4; k++) mc(0, 1, 0, 3'b010, nx(a, k[1:0]), 0);
            mc(0, 1, 0, 3'b010, a, 0);
            for (k = 1; k < 4; k++) mc(0, 0, 0, 3'b010, a, 0);
            idle;
            ax(0, 8'h04, 0); ck("order", 36'(ord), {35'h0, q[2]});
        end
        mc(0, 1, 1, 3'b010, 10'h300, $random(seed));
        repeat (2) mc(1, 1, 0, 3'b010, 0, 0);
        mc(0, 1, 0, 3'b010, 10'h300, 0);
        repeat (2) mc(1, 1, 1, 3'b010, 0, 0);
        idle;
        slp <= 1; repeat (4) @(posedge clk_i);
        ax(0, 8'h04, 0); ck("asleep", 36'h1, {35'h0, q[0]});
        slp <= 0; repeat (3) @(posedge clk_i);
        for (i = 0; i < 8; i++) mc(0, 1, 0, 3'b010, 10'h100 + i, 0);
        idle;
        for (i = 0; i < 16; i++) mc(0, 1, 1, 3'b010, 10'h3C0 + i, $random(seed));
        for (i = 0; i < 300; i++) begin
            q = $random(seed); a = 10'h3C0 + q[7:4];
            // Same-edge read and write of one word is left undefined
            if (q[8] && rdp && a == ra) a ^= 10'h1;
            mc(q[0] & q[1], !opw | q[2], q[8], q[10:9] == 0 ? q[13:11] : 3'b010, a,
               {q, q[3:0]});
        end
        idle;
        ax(0, 8'h08, 0); ck("stalls", 36'(nst), {4'h0, q});
        finish_test;
    end
endmodule
`default_nettype wire
